// ### hls_defines.vh
// hls_defines.vh: shared constants for the hardware loop sequencer
// assumes: included by its bare name from every design file of the block
`ifndef HLS_DEFINES_VH
`define HLS_DEFINES_VH

`define HLS_ADDR_W 32
`define HLS_CNT_W 32
`define HLS_STACK_DEPTH 6
`define HLS_PTR_W 3
`define HLS_COND_W 5
// loop type codes stored with each stack entry
`define HLS_TYPE_W 2
`define HLS_TYPE_COUNT 2'h0
`define HLS_TYPE_ARITH 2'h1
`define HLS_TYPE_FOREVER 2'h2
// flush depth: stages from the fourth memory stage back to the first fetch stage; pipeline depth is one more
`define HLS_FLUSH_STAGES 4'ha
`define HLS_PIPE_DEPTH 4'hb
`define HLS_SHORT_LIMIT 32'h0000000b
`define HLS_EMPTY_ADDR 32'hffffffff
// entry layout: {late, type, cond, end address}
`define HLS_ENTRY_W 40
`define HLS_F_ADDR_LSB 0
`define HLS_F_COND_LSB 32
`define HLS_F_TYPE_LSB 37
`define HLS_F_LATE_BIT 39

`endif

// ### hls_loop_seq.v
// hls_loop_seq.v: hardware loop sequencer for an eleven-stage pipeline
// assumes: fetch unit reports the first-fetch address, execute pipe reports its last-stage
// instruction and condition result; same clock throughout
//
// Contract
// - late-check loop decrements and tests count when end address is in last execute stage
// - late-check loop finishes when count is one with valid end in last execute stage
// - late-check exit flushes fourth memory stage back to first fetch, ten lost cycles
// - on exit pop loop and pc stacks, fetch instruction after end address next cycle
// - end address in first fetch and loop unfinished: branch back to top next cycle
// - loop-start opcode selects early or late check
// - loops unrolling to fewer than eleven instructions always use late check
// - force-late mode bit makes every counter loop late check
// - arithmetic loop of three or more tested when end-minus-two is in last execute stage
// - arithmetic loop of one or two tested when its end is in last execute stage
// - arithmetic test true lets one more instruction run, flushes the younger ones
// - after arithmetic exit fetch end instruction next cycle, then sequential ones
// - one-instruction loop tested every cycle; one and two instruction loops overrun
// - endless loop repeats until interrupt or reset
// - loop start pushes end address, condition code and loop type on loop stack
// - loop stack saves addresses and counts automatically for nesting
// - early-check loop pops stack before end instruction reaches last execute stage
// - after early-check exit top-address read returns next entry's end address
// - late-check loop top-address read returns its own entry's end address
// - loop start pushes top-of-loop address and type on pc stack
// - loop address stack holds six 32-bit entries; seventh push overflows
// - top-address read with empty stack returns all ones
// - initial count of zero runs the loop two to the thirty-second times
`timescale 1ns/100ps
`include "hls_defines.vh"

module hls_loop_seq (
  input wire ref_clk_i,
  input wire reset_i,
  input wire force_late_loop_check_i,
  input wire start_valid_i,
  input wire start_early_i,
  input wire [`HLS_TYPE_W-1:0] start_type_i,
  input wire [`HLS_COND_W-1:0] start_cond_i,
  input wire [`HLS_ADDR_W-1:0] start_end_addr_i,
  input wire [`HLS_ADDR_W-1:0] start_top_addr_i,
  input wire [`HLS_CNT_W-1:0] initial_loop_count_i,
  input wire [`HLS_ADDR_W-1:0] fetch_addr_i,
  input wire fetch_valid_i,
  input wire [`HLS_ADDR_W-1:0] exec_addr_i,
  input wire exec_valid_i,
  input wire cond_true_i,
  input wire abort_i,
  output reg redirect_o,
  output reg [`HLS_ADDR_W-1:0] redirect_addr_o,
  output reg flush_o,
  output reg flush_keep_one_o,
  output reg [`HLS_ADDR_W-1:0] top_loop_end_address_o,
  output reg [`HLS_CNT_W-1:0] current_loop_count_o,
  output reg pc_push_o,
  output reg [`HLS_ADDR_W-1:0] pc_push_addr_o,
  output reg [`HLS_TYPE_W-1:0] pc_push_type_o,
  output reg pc_pop_o,
  output reg overflow_o
);

  ////////////////////////////////////////////////////////////////////////////
  // stack state

  reg [`HLS_PTR_W-1:0] depth_reg;
  reg [`HLS_PTR_W-1:0] depth_next;
  reg [`HLS_ADDR_W-1:0] top_addr_reg [0:`HLS_STACK_DEPTH-1];
  reg [`HLS_CNT_W-1:0] count_stack_reg [0:`HLS_STACK_DEPTH-1];
  reg [`HLS_CNT_W-1:0] current_loop_count_reg;
  reg [`HLS_CNT_W-1:0] current_loop_count_next;
  reg popped_early_reg;
  reg popped_early_next;
  reg [`HLS_ADDR_W-1:0] early_end_reg;
  reg [`HLS_ADDR_W-1:0] early_end_next;
  reg [`HLS_ADDR_W-1:0] top_start_reg;
  reg [`HLS_ADDR_W-1:0] top_start_next;
  wire [`HLS_ENTRY_W-1:0] top_entry;
  wire [`HLS_ENTRY_W-1:0] push_entry;
  wire [`HLS_PTR_W-1:0] top_idx;
  wire [`HLS_PTR_W-1:0] rd_idx;
  reg stack_valid_reg;

  wire active = (depth_reg != 3'h0) && stack_valid_reg;
  wire [`HLS_ADDR_W-1:0] cur_end = top_entry[`HLS_F_ADDR_LSB +: `HLS_ADDR_W];
  wire [`HLS_TYPE_W-1:0] cur_type = top_entry[`HLS_F_TYPE_LSB +: `HLS_TYPE_W];
  wire cur_late = top_entry[`HLS_F_LATE_BIT];
  wire [`HLS_ADDR_W-1:0] cur_top = top_addr_reg[top_idx];
  wire [`HLS_ADDR_W-1:0] body_len = cur_end - cur_top + 32'h00000001;
  assign top_idx = depth_reg - 3'h1;

  wire [63:0] unrolled = {32'h0, start_end_addr_i - start_top_addr_i + 32'h00000001} *
                         {(initial_loop_count_i == 32'h0) ? 32'hffffffff : initial_loop_count_i};
  wire start_late = force_late_loop_check_i || !start_early_i ||
                    (initial_loop_count_i != 32'h0 && unrolled < {32'h0, `HLS_SHORT_LIMIT});
  // short body: start is seen in the last stage after the end was fetched, so refetch from top
  wire start_short = (start_end_addr_i - start_top_addr_i) < {28'h0, `HLS_FLUSH_STAGES};
  assign push_entry = {start_late, start_type_i, start_cond_i, start_end_addr_i};

  ////////////////////////////////////////////////////////////////////////////
  // termination detection

  wire is_count = (cur_type == `HLS_TYPE_COUNT);
  wire is_arith = (cur_type == `HLS_TYPE_ARITH);
  wire fetch_at_end = active && fetch_valid_i && (fetch_addr_i == cur_end) && !popped_early_reg;
  // late count test in last stage
  wire late_done = active && is_count && cur_late && exec_valid_i && exec_addr_i == cur_end &&
                   current_loop_count_reg == 32'h00000001;
  // early count test at first fetch
  wire early_done = fetch_at_end && is_count && !cur_late && current_loop_count_reg == 32'h00000001;
  // arithmetic test point; one-instruction loop hits every cycle
  wire [`HLS_ADDR_W-1:0] arith_probe = (body_len >= 32'h00000003) ? cur_end - 32'h00000002 : cur_end;
  wire arith_done = active && is_arith && exec_valid_i && exec_addr_i == arith_probe && cond_true_i;
  // endless loops never end here; only abort or reset leaves them
  wire any_pop = late_done || early_done || arith_done || (active && abort_i);

  wire mem_wr = start_valid_i && depth_reg != 3'h6 && !any_pop;
  assign rd_idx = mem_wr ? depth_reg : (any_pop && depth_reg > 3'h1) ? depth_reg - 3'h2 : top_idx;

  hls_stack_mem u_mem (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .wr_en_i(mem_wr),
    .wr_idx_i(depth_reg),
    .wr_data_i(push_entry),
    .rd_idx_i(rd_idx),
    .rd_data_o(top_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always @* begin
    depth_next = depth_reg;
    current_loop_count_next = current_loop_count_reg;
    popped_early_next = popped_early_reg;
    early_end_next = early_end_reg;
    top_start_next = cur_top;
    if (any_pop) begin
      depth_next = depth_reg - 3'h1;
      popped_early_next = 1'b0;
      current_loop_count_next = (depth_reg > 3'h1) ? count_stack_reg[depth_reg - 3'h2] : `HLS_EMPTY_ADDR;
    end else if (mem_wr) begin
      depth_next = depth_reg + 3'h1;
      current_loop_count_next = initial_loop_count_i;
      popped_early_next = 1'b0;
      top_start_next = start_top_addr_i;
    end else if (active && is_count && current_loop_count_reg != 32'h00000001) begin
      // zero wraps to all ones, giving two to the 32nd passes
      if ((cur_late && exec_valid_i && exec_addr_i == cur_end) || (!cur_late && fetch_at_end)) begin
        current_loop_count_next = current_loop_count_reg - 32'h00000001;
      end
    end
    if (early_done) begin
      early_end_next = cur_end;
    end
  end

  // end address of the entry beneath the top, kept beside the memory so a pop reads it at once
  reg [`HLS_ADDR_W-1:0] end_shadow_reg [0:`HLS_STACK_DEPTH-1];
  wire [`HLS_ADDR_W-1:0] top_entry_below = (depth_reg > 3'h1) ? end_shadow_reg[depth_reg - 3'h2] :
                                            `HLS_EMPTY_ADDR;
  integer j;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (j = 0; j < `HLS_STACK_DEPTH; j = j + 1) begin
        end_shadow_reg[j] <= {`HLS_ADDR_W{1'b0}};
      end
    end else if (mem_wr) begin
      end_shadow_reg[depth_reg] <= start_end_addr_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  integer i;
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      depth_reg <= 3'h0;
      stack_valid_reg <= 1'b0;
      current_loop_count_reg <= `HLS_EMPTY_ADDR;
      popped_early_reg <= 1'b0;
      early_end_reg <= {`HLS_ADDR_W{1'b0}};
      top_start_reg <= {`HLS_ADDR_W{1'b0}};
      redirect_o <= 1'b0;
      redirect_addr_o <= {`HLS_ADDR_W{1'b0}};
      flush_o <= 1'b0;
      flush_keep_one_o <= 1'b0;
      top_loop_end_address_o <= `HLS_EMPTY_ADDR;
      current_loop_count_o <= `HLS_EMPTY_ADDR;
      pc_push_o <= 1'b0;
      pc_push_addr_o <= {`HLS_ADDR_W{1'b0}};
      pc_push_type_o <= `HLS_TYPE_COUNT;
      pc_pop_o <= 1'b0;
      overflow_o <= 1'b0;
      for (i = 0; i < `HLS_STACK_DEPTH; i = i + 1) begin
        top_addr_reg[i] <= {`HLS_ADDR_W{1'b0}};
        count_stack_reg[i] <= {`HLS_CNT_W{1'b0}};
      end
    end else begin
      depth_reg <= depth_next;
      stack_valid_reg <= (depth_next != 3'h0);
      current_loop_count_reg <= current_loop_count_next;
      popped_early_reg <= popped_early_next;
      early_end_reg <= early_end_next;
      top_start_reg <= top_start_next;
      if (mem_wr) begin
        top_addr_reg[depth_reg] <= start_top_addr_i;
      end
      // a push must not overwrite the saved count of the loop beneath it
      if (!any_pop && !mem_wr && active) begin
        count_stack_reg[top_idx] <= current_loop_count_next;
      end
      if (mem_wr) begin
        count_stack_reg[depth_reg] <= initial_loop_count_i;
      end
      overflow_o <= start_valid_i && depth_reg == 3'h6 && !any_pop;
      // top-of-loop and type onto pc stack
      pc_push_o <= mem_wr;
      pc_push_addr_o <= start_top_addr_i;
      pc_push_type_o <= start_type_i;
      pc_pop_o <= any_pop;
      // late exit flushes ten younger stages
      flush_o <= late_done || arith_done || (mem_wr && start_short);
      // arithmetic exit keeps one more instruction
      flush_keep_one_o <= arith_done;
      redirect_o <= 1'b0;
      if (late_done || early_done) begin
        redirect_o <= 1'b1;
        redirect_addr_o <= cur_end + 32'h00000001;
      end else if (arith_done) begin
        // refetch the end instruction, then run sequentially
        redirect_o <= 1'b1;
        redirect_addr_o <= cur_end;
      end else if (mem_wr && start_short) begin
        // restart a short body from its top
        redirect_o <= 1'b1;
        redirect_addr_o <= start_top_addr_i;
      end else if (fetch_at_end) begin
        redirect_o <= 1'b1;
        redirect_addr_o <= cur_top;
      end
      if (depth_next == 3'h0) begin
        top_loop_end_address_o <= `HLS_EMPTY_ADDR;
      end else if (mem_wr) begin
        top_loop_end_address_o <= start_end_addr_i;
      end else if (any_pop) begin
        top_loop_end_address_o <= top_entry_below;
      end else begin
        top_loop_end_address_o <= cur_end;
      end
      current_loop_count_o <= current_loop_count_next;
    end
  end

endmodule // hls_loop_seq

// ### hls_loop_seq_monitor.sv
// hls_loop_seq_monitor.sv: port-level checks on the loop sequencer
// assumes: bound to hls_loop_seq; one clock, sync active-high reset
`timescale 1ns/100ps
`include "hls_defines.vh"
module hls_loop_seq_monitor (
  input wire ref_clk_i,
  input wire reset_i,
  input wire start_valid_i,
  input wire [`HLS_TYPE_W-1:0] start_type_i,
  input wire [`HLS_ADDR_W-1:0] start_end_addr_i,
  input wire [`HLS_ADDR_W-1:0] start_top_addr_i,
  input wire redirect_o,
  input wire [`HLS_ADDR_W-1:0] redirect_addr_o,
  input wire flush_o,
  input wire flush_keep_one_o,
  input wire [`HLS_ADDR_W-1:0] top_loop_end_address_o,
  input wire [`HLS_CNT_W-1:0] current_loop_count_o,
  input wire pc_push_o,
  input wire [`HLS_ADDR_W-1:0] pc_push_addr_o,
  input wire [`HLS_TYPE_W-1:0] pc_push_type_o,
  input wire pc_pop_o,
  input wire overflow_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////
  a_push_pc_data: assert property (pc_push_o |-> $past(start_valid_i) && pc_push_addr_o == $past(start_top_addr_i)
    && pc_push_type_o == $past(start_type_i)) else $error("pc push data wrong");
  a_push_loop_top: assert property (pc_push_o |-> top_loop_end_address_o == $past(start_end_addr_i))
    else $error("loop top not the pushed end address");
  a_overflow_refused: assert property (overflow_o |-> !pc_push_o && $past(start_valid_i))
    else $error("overflow without refused start");
  a_exit_pops_both: assert property (flush_o && !pc_push_o |-> redirect_o && pc_pop_o) else $error("exit without pop");
  a_late_exit_target: assert property (flush_o && !flush_keep_one_o && !pc_push_o |->
    redirect_addr_o == $past(top_loop_end_address_o) + 32'h1) else $error("late exit target wrong");
  a_arith_exit_target: assert property (flush_keep_one_o |->
    redirect_o && redirect_addr_o == $past(top_loop_end_address_o)) else $error("arith exit target wrong");
  a_reset_empty_ones: assert property ($past(reset_i) |-> top_loop_end_address_o == `HLS_EMPTY_ADDR
    && current_loop_count_o == 32'hffffffff) else $error("empty stack not all ones");
  // the stage behind a late exit is itself flushed, so a second exit cannot follow at once
  a_flush_single: assert property (flush_o |=> !flush_o && !flush_keep_one_o) else $error("double flush");
  c_late_exit: cover property (flush_o && !flush_keep_one_o);
  c_arith_exit: cover property (flush_keep_one_o);
  c_overflow: cover property (overflow_o);
endmodule // hls_loop_seq_monitor

bind hls_loop_seq hls_loop_seq_monitor u_hls_loop_seq_monitor (.*);

// ### hls_loop_seq_tb.sv
// hls_loop_seq_tb.sv: self-checking bench for the loop sequencer
// assumes: hls_pipe_model plays fetch unit and execute pipe; loop-start sits at DO_A
`timescale 1ns/100ps
`include "hls_defines.vh"
module hls_loop_seq_tb;
  localparam logic [31:0] DO_A = 32'h00000010;
  localparam logic [31:0] ONES = 32'hffffffff;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic force_late = 1'b0, early = 1'b0, tb_start = 1'b0, cond_true = 1'b0, abort = 1'b0;
  logic [1:0] typ = 2'h0;
  logic [31:0] end_a = 32'h0, cnt = 32'h1, tb_end = 32'h0, boot_a = DO_A, top_at_end, keep_addr, flush_addr;
  wire redirect, flush, keep, pop, ovf, fv, ev;
  wire [31:0] raddr, top, count, fa, ea;
  int n_mismatch = 0, total_checks = 0, cycles = 0, n_end, n_back, n_flush, n_keep, n_pop, pop_at_end;
  wire start_v = tb_start | (ev & (ea == DO_A));
  hls_loop_seq u_hls_loop_seq (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .force_late_loop_check_i(force_late),
    .start_valid_i(start_v), .start_early_i(early), .start_type_i(typ), .start_cond_i(5'h0f),
    .start_end_addr_i(tb_start ? tb_end : end_a), .start_top_addr_i(DO_A + 32'h1), .initial_loop_count_i(cnt),
    .fetch_addr_i(fa), .fetch_valid_i(fv), .exec_addr_i(ea), .exec_valid_i(ev), .cond_true_i(cond_true),
    .abort_i(abort), .redirect_o(redirect), .redirect_addr_o(raddr), .flush_o(flush), .flush_keep_one_o(keep),
    .top_loop_end_address_o(top), .current_loop_count_o(count), .pc_push_o(), .pc_push_addr_o(),
    .pc_push_type_o(), .pc_pop_o(pop), .overflow_o(ovf));
  hls_pipe_model u_hls_pipe_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .boot_addr_i(boot_a),
    .redirect_i(redirect), .redirect_addr_i(raddr), .flush_i(flush), .keep_one_i(keep), .fetch_addr_o(fa),
    .fetch_valid_o(fv), .exec_addr_o(ea), .exec_valid_o(ev));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (!reset_i) begin
      if (ev && ea == end_a) begin
        n_end++;
        top_at_end = top;
      end
      if (redirect && raddr == DO_A + 32'h1) n_back++;
      if (flush && pop) begin
        n_flush++;
        flush_addr = raddr;
      end
      if (keep) begin
        n_keep++;
        keep_addr = raddr;
      end
      if (pop) begin
        n_pop++;
        pop_at_end = n_end;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_reset();
    reset_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    {n_end, n_back, n_flush, n_keep, n_pop, pop_at_end} = {6{32'sd0}};
  endtask
  // runs one loop at DO_A with the given body length; arithmetic exits in its second pass
  task automatic run_loop(input logic e, input logic f, input logic [1:0] t, input logic [31:0] len, input logic [31:0] c);
    {early, force_late, typ, cnt, end_a} = {e, f, t, c, DO_A + len};
    do_reset();
    repeat (90) begin
      @(posedge ref_clk_i);
      #1;
      cond_true = (t == `HLS_TYPE_ARITH) && ev && (ea == end_a - 32'h2) && (n_end == 1);
    end
  endtask
  task automatic t_late();
    run_loop(1'b0, 1'b0, `HLS_TYPE_COUNT, 32'hb, 32'h2);
    chk("late ends", n_end, 2);
    chk("late flush", n_flush, 1);
    chk("late target", flush_addr, end_a + 32'h1);
    chk("late loopbacks", n_back, 2);
    chk("late top", top_at_end, end_a);
  endtask
  task automatic t_early();
    run_loop(1'b1, 1'b0, `HLS_TYPE_COUNT, 32'hb, 32'h2);
    chk("early flush", n_flush, 0);
    chk("early ends", n_end, 2);
    chk("early pop", pop_at_end, 1);
    chk("early top", top_at_end, ONES);
  endtask
  task automatic t_force();
    run_loop(1'b1, 1'b1, `HLS_TYPE_COUNT, 32'hb, 32'h2);
    chk("forced flush", n_flush, 1);
  endtask
  task automatic t_short();
    run_loop(1'b1, 1'b0, `HLS_TYPE_COUNT, 32'h5, 32'h2);
    chk("short flush", n_flush, 1);
    chk("short ends", n_end, 2);
  endtask
  task automatic t_arith();
    run_loop(1'b0, 1'b0, `HLS_TYPE_ARITH, 32'hb, 32'h1);
    chk("arith keep", n_keep, 1);
    chk("arith target", keep_addr, end_a);
    chk("arith ends", n_end, 2);
  endtask
  task automatic t_endless();
    run_loop(1'b0, 1'b0, `HLS_TYPE_FOREVER, 32'hb, 32'h1);
    chk("endless loops", n_back > 5, 1);
    chk("endless no pop", n_pop, 0);
    abort = 1'b1;
    @(posedge ref_clk_i);
    #1;
    abort = 1'b0;
    chk("abort pops", top, ONES);
  endtask
  task automatic t_stack();
    {boot_a, typ} = {32'h00000100, `HLS_TYPE_COUNT};
    do_reset();
    chk("empty top", top, ONES);
    for (int i = 0; i < 7; i++) begin
      {tb_end, cnt, tb_start} = {32'h0000f000 + i, 32'h00000100 + i, 1'b1};
      @(posedge ref_clk_i);
      #1;
      tb_start = 1'b0;
      chk("push top", top, 32'h0000f000 + (i < 6 ? i : 5));
      chk("push count", count, 32'h00000100 + (i < 6 ? i : 5));
      chk("overflow", ovf, i == 6);
      @(posedge ref_clk_i);
      #1;
    end
    for (int i = 5; i >= 0; i--) begin
      abort = 1'b1;
      @(posedge ref_clk_i);
      #1;
      abort = 1'b0;
      chk("pop top", top, i > 0 ? 32'h0000f000 + i - 1 : ONES);
      chk("pop count", count, i > 0 ? 32'h00000100 + i - 1 : ONES);
      @(posedge ref_clk_i);
      #1;
    end
    boot_a = DO_A;
  endtask
  initial begin
    t_stack();
    t_late();
    t_early();
    t_force();
    t_short();
    t_arith();
    t_endless();
    tally_and_finish();
  end
endmodule // hls_loop_seq_tb

// ### hls_pipe_model.sv
// hls_pipe_model.sv: fetch unit and eleven-stage pipe facing the loop sequencer
// assumes: redirect and flush arrive registered and act in the cycle they stand
`timescale 1ns/100ps
`include "hls_defines.vh"
module hls_pipe_model (
  input wire ref_clk_i,
  input wire reset_i,
  input wire [`HLS_ADDR_W-1:0] boot_addr_i,
  input wire redirect_i,
  input wire [`HLS_ADDR_W-1:0] redirect_addr_i,
  input wire flush_i,
  input wire keep_one_i,
  output logic [`HLS_ADDR_W-1:0] fetch_addr_o,
  output logic fetch_valid_o,
  output logic [`HLS_ADDR_W-1:0] exec_addr_o,
  output logic exec_valid_o
);
  // stage 1 is the second fetch stage, stage 10 the last execute stage
  logic [`HLS_ADDR_W-1:0] pc_reg;
  logic [`HLS_ADDR_W-1:0] st_reg [1:10];
  logic [10:1] vld_reg;
  assign fetch_addr_o = redirect_i ? redirect_addr_i : pc_reg;
  assign fetch_valid_o = !reset_i;
  // a killed slot shows the inverted address so nothing stale matches
  assign exec_valid_o = vld_reg[10] & (~flush_i | keep_one_i);
  assign exec_addr_o = exec_valid_o ? st_reg[10] : ~st_reg[10];
  ////////////////////////////////////////////////////////////////
  // no stack access
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      pc_reg <= boot_addr_i;
      vld_reg <= 10'h000;
    end else begin
      pc_reg <= fetch_addr_o + 32'h1;
      st_reg[1] <= fetch_addr_o;
      for (int i = 2; i <= 10; i++) st_reg[i] <= st_reg[i-1];
      vld_reg <= flush_i ? 10'h001 : {vld_reg[9:1], 1'b1};
    end
  end
endmodule // hls_pipe_model

// ### hls_stack_mem.v
// hls_stack_mem.v: six-entry loop stack storage with registered top-of-stack read
// assumes: caller never writes and reads the same entry with conflicting intent
`timescale 1ns/100ps
`include "hls_defines.vh"

module hls_stack_mem (
  input wire ref_clk_i,
  input wire reset_i,
  input wire wr_en_i,
  input wire [`HLS_PTR_W-1:0] wr_idx_i,
  input wire [`HLS_ENTRY_W-1:0] wr_data_i,
  input wire [`HLS_PTR_W-1:0] rd_idx_i,
  output reg [`HLS_ENTRY_W-1:0] rd_data_o
);

  reg [`HLS_ENTRY_W-1:0] mem [0:`HLS_STACK_DEPTH-1];

  always @(posedge ref_clk_i) begin
    if (wr_en_i) begin
      mem[wr_idx_i] <= wr_data_i;
    end
  end

  // read data out of a register; the writer bypasses so a fresh push is visible at once
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      rd_data_o <= {`HLS_ENTRY_W{1'b0}};
    end else if (wr_en_i && wr_idx_i == rd_idx_i) begin
      rd_data_o <= wr_data_i;
    end else begin
      rd_data_o <= mem[rd_idx_i];
    end
  end

endmodule // hls_stack_mem
